/* shared/ext_bus_pkg.sv */
// Constants and types for the external memory bus controller
package ext_bus_pkg;
	// Reset and configuration sequence
	localparam int RESET_MIN_STATES = 16;
	localparam int RESET_SEQ_STATES = 10;
	localparam logic [15:0] CFG_ADDR0 = 16'h2018;
	localparam logic [15:0] CFG_ADDR1 = 16'h201A;
	localparam logic [15:0] START_ADDR = 16'h2080;
	// Fields of the first configuration byte
	localparam int CFG0_WIDTH_BIT = 1;
	localparam int CFG0_WRMODE_BIT = 2;
	localparam int CFG0_ADV_BIT = 3;
	localparam int CFG0_WAIT_LSB = 4;
	// Fields of the second configuration byte
	localparam int CFG1_WIDTH_BIT = 2;
	// Values after reset
	localparam logic [7:0] CFG0_RESET = 8'h02;
	localparam logic [7:0] CFG1_RESET = 8'h04;
	localparam logic [15:0] PSW_RESET = 16'h0000;
	// Wait-state limit field width
	localparam int WAIT_W = 2;
	// Bus cycle phases, each one state time (two oscillator periods)
	typedef enum logic [4:0] {
		PH_IDLE = 5'h01,
		PH_ADDR = 5'h02,
		PH_DATA = 5'h04,
		PH_WAIT = 5'h08,
		PH_END = 5'h10
	} bus_phase_t;
	// Reset sequence states
	typedef enum logic [3:0] {
		SQ_HOLD = 4'h1,
		SQ_CFG0 = 4'h2,
		SQ_CFG1 = 4'h4,
		SQ_RUN = 4'h8
	} seq_state_t;
endpackage

/* rtl/pin_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic pin_i,
	input wire logic rst_val_i,
	output logic level_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	// Chain; first stage only feeds the second
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	// Change counts once stages two and three agree
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			level_o <= 1'b0;
		end else if (s2_q == s3_q) begin
			level_o <= s3_q;
		end
	end
	logic unused_rst;
	assign unused_rst = rst_val_i;
endmodule

/* rtl/ext_bus_ctrl.sv */
// External memory bus control: bus clock, strobes, width, reset config fetch
`timescale 1ns/10ps
module ext_bus_ctrl
	import ext_bus_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Core request side
	input wire logic req_i,
	input wire logic req_write_i,
	input wire logic req_fetch_i,
	input wire logic req_word_i,
	input wire logic [15:0] req_addr_i,
	input wire logic [15:0] req_wdata_i,
	input wire logic req_internal_range_i,
	output logic req_done_o,
	output logic [15:0] req_rdata_o,
	output logic req_internal_o,
	// Pin-side inputs
	input wire logic width_select_in_i,
	input wire logic ready_i,
	input wire logic external_access_sel_n_i,
	input wire logic [15:0] ad_in_i,
	// Pin function selects and port-mode values
	input wire logic [7:0] pin_func_en_i,
	input wire logic [7:0] general_port_io_i,
	// Pins
	output logic bus_clock_out_o,
	output logic addr_strobe_o,
	output logic rd_n_o,
	output logic write_low_strobe_n_o,
	output logic write_high_strobe_n_o,
	output logic fetch_indicator_o,
	output logic [15:0] ad_out_o,
	output logic ad_oe_n_o,
	// Status
	output logic [7:0] chip_config_byte0_o,
	output logic [7:0] chip_config_byte1_o,
	output logic [15:0] processor_status_word_o,
	output logic [15:0] start_pc_o,
	output logic seq_busy_o
);
	logic ph_q;
	logic state_en;
	logic clk_q;
	logic width_s;
	logic ready_s;
	logic ea_s;
	logic ea_latched_q;
	logic ea_capture_q;
	bus_phase_t phase_q;
	seq_state_t seq_q;
	logic [3:0] seq_cnt_q;
	logic [7:0] cfg0_q;
	logic [7:0] cfg1_q;
	logic [WAIT_W-1:0] wait_cnt_q;
	logic cyc_write_q;
	logic cyc_fetch_q;
	logic cyc_wide_q;
	logic cyc_a0_q;
	logic cyc_hi_q;
	logic [15:0] cyc_addr_q;
	logic [15:0] cyc_wdata_q;
	logic cyc_is_cfg_q;
	logic bus_strobe;
	logic adv_mode;
	logic [WAIT_W-1:0] wait_lim;
	logic cfg_req;
	logic [15:0] cfg_addr;
	logic core_ext;
	logic start_cycle;

	pin_sync u_sync_width (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.pin_i(width_select_in_i), .rst_val_i(1'b0), .level_o(width_s));
	pin_sync u_sync_ready (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.pin_i(ready_i), .rst_val_i(1'b0), .level_o(ready_s));
	pin_sync u_sync_ea (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.pin_i(external_access_sel_n_i), .rst_val_i(1'b0), .level_o(ea_s));

	// State-time divider; starts at release so the bus clock is resynced
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ph_q <= 1'b0;
		end else begin
			ph_q <= ~ph_q;
		end
	end
	assign state_en = ph_q;

	// Bus clock: toggles every oscillator cycle, equal halves
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			clk_q <= 1'b0;
		end else begin
			clk_q <= ~ph_q;
		end
	end

	// Access select caught once the synchroniser has settled after release
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ea_latched_q <= 1'b0;
			ea_capture_q <= 1'b1;
		end else if (ea_capture_q && seq_q == SQ_CFG0 && seq_cnt_q >= 4'h2) begin
			ea_latched_q <= ea_s;
			ea_capture_q <= 1'b0;
		end
	end

	// Configuration fetch is always external since the on-chip map is unknown yet
	assign cfg_req = (seq_q == SQ_CFG0) || (seq_q == SQ_CFG1);
	assign cfg_addr = (seq_q == SQ_CFG0) ? CFG_ADDR0 : CFG_ADDR1;
	// Low select sends the on-chip range off chip
	assign core_ext = req_i && (!req_internal_range_i || !ea_latched_q);
	assign start_cycle = state_en && phase_q == PH_IDLE &&
		((cfg_req && seq_cnt_q >= 4'h2) || (seq_q == SQ_RUN && core_ext));
	assign adv_mode = cfg0_q[CFG0_ADV_BIT];
	assign wait_lim = cfg0_q[CFG0_WAIT_LSB +: WAIT_W];

	// Reset sequence: ten state times, two config reads, then run
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			seq_q <= SQ_HOLD;
			seq_cnt_q <= 4'h0;
			processor_status_word_o <= PSW_RESET;
			start_pc_o <= 16'h0000;
		end else if (state_en && seq_q != SQ_RUN) begin
			seq_cnt_q <= seq_cnt_q + 4'h1;
			unique case (seq_q)
				SQ_HOLD: begin
					processor_status_word_o <= PSW_RESET;
					seq_q <= SQ_CFG0;
				end
				SQ_CFG0: begin
					if (phase_q == PH_END) seq_q <= SQ_CFG1;
				end
				SQ_CFG1: begin
					if (phase_q == PH_END && seq_cnt_q >= 4'(RESET_SEQ_STATES - 1)) begin
						seq_q <= SQ_RUN;
						start_pc_o <= START_ADDR;
					end
				end
				SQ_RUN: begin
					seq_q <= SQ_RUN;
				end
			endcase
		end
	end

	// Bus cycle phases, one state time each
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			phase_q <= PH_IDLE;
			wait_cnt_q <= '0;
		end else if (state_en) begin
			unique case (phase_q)
				PH_IDLE: if (start_cycle) phase_q <= PH_ADDR;
				PH_ADDR: begin
					phase_q <= PH_DATA;
					wait_cnt_q <= '0;
				end
				PH_DATA, PH_WAIT: begin
					// Ready low before the falling edge stalls, capped by config
					if (!ready_s && wait_cnt_q < wait_lim) begin
						phase_q <= PH_WAIT;
						wait_cnt_q <= wait_cnt_q + WAIT_W'(1);
					end else begin
						phase_q <= PH_END;
					end
				end
				PH_END: phase_q <= PH_IDLE;
			endcase
		end
	end

	// Latch cycle attributes at cycle start
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cyc_write_q <= 1'b0;
			cyc_fetch_q <= 1'b0;
			cyc_wide_q <= 1'b0;
			cyc_a0_q <= 1'b0;
			cyc_hi_q <= 1'b0;
			cyc_addr_q <= 16'h0000;
			cyc_wdata_q <= 16'h0000;
			cyc_is_cfg_q <= 1'b0;
		end else if (start_cycle) begin
			cyc_is_cfg_q <= cfg_req;
			cyc_write_q <= cfg_req ? 1'b0 : req_write_i;
			cyc_fetch_q <= cfg_req ? 1'b0 : req_fetch_i && !req_write_i;
			cyc_addr_q <= cfg_req ? cfg_addr : req_addr_i;
			cyc_wdata_q <= req_wdata_i;
			cyc_a0_q <= cfg_req ? 1'b0 : req_addr_i[0];
			cyc_hi_q <= cfg_req ? 1'b0 : (req_word_i || req_addr_i[0]);
			// Width: pin, fixed 16 or fixed 8; both clear also gives fixed 8
			unique case ({cfg0_q[CFG0_WIDTH_BIT], cfg1_q[CFG1_WIDTH_BIT]})
				2'b11: cyc_wide_q <= width_s;
				2'b10: cyc_wide_q <= 1'b1;
				2'b01: cyc_wide_q <= 1'b0;
				2'b00: cyc_wide_q <= 1'b0;
			endcase
		end
	end

	// Configuration bytes loaded from the first two external reads
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg0_q <= CFG0_RESET;
			cfg1_q <= CFG1_RESET;
		end else if (state_en && phase_q == PH_END && cyc_is_cfg_q) begin
			if (seq_q == SQ_CFG0) cfg0_q <= ad_in_i[7:0];
			else cfg1_q <= ad_in_i[7:0];
		end
	end

	assign bus_strobe = phase_q != PH_IDLE;

	// Pin drivers; a disabled function falls back to its port value
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_clock_out_o <= 1'b0;
			addr_strobe_o <= 1'b0; // Latch-pulse form after reset, so idle is low
			rd_n_o <= 1'b1;
			write_low_strobe_n_o <= 1'b1;
			write_high_strobe_n_o <= 1'b1;
			fetch_indicator_o <= 1'b0;
			ad_out_o <= 16'h0000;
			ad_oe_n_o <= 1'b1;
		end else begin
			bus_clock_out_o <= pin_func_en_i[0] ? clk_q : general_port_io_i[0];
			// Latch pulse in address phase, or valid low for whole cycle
			if (pin_func_en_i[1])
				addr_strobe_o <= adv_mode ? !bus_strobe
					: (phase_q == PH_ADDR && !ph_q);
			else
				addr_strobe_o <= general_port_io_i[1];
			if (pin_func_en_i[2])
				rd_n_o <= !(bus_strobe && phase_q != PH_ADDR && !cyc_write_q);
			else
				rd_n_o <= general_port_io_i[2];
			// Write-all form or even-byte-only form
			if (pin_func_en_i[3])
				write_low_strobe_n_o <= !((phase_q == PH_DATA || phase_q == PH_WAIT)
					&& cyc_write_q && (!cfg0_q[CFG0_WRMODE_BIT] || !cyc_a0_q));
			else
				write_low_strobe_n_o <= general_port_io_i[3];
			// High byte enable, or odd-byte write strobe, 16-bit cycles only
			if (pin_func_en_i[4])
				write_high_strobe_n_o <= cfg0_q[CFG0_WRMODE_BIT]
					? !((phase_q == PH_DATA || phase_q == PH_WAIT) && cyc_write_q
						&& cyc_wide_q && cyc_hi_q)
					: !(bus_strobe && cyc_wide_q && cyc_hi_q);
			else
				write_high_strobe_n_o <= general_port_io_i[4];
			if (pin_func_en_i[5])
				fetch_indicator_o <= bus_strobe && cyc_fetch_q;
			else
				fetch_indicator_o <= general_port_io_i[5];
			// Address then write data on the shared lines
			ad_out_o <= (phase_q == PH_ADDR) ? cyc_addr_q : cyc_wdata_q;
			ad_oe_n_o <= !(phase_q == PH_ADDR || (bus_strobe && cyc_write_q));
		end
	end

	// Completion back to the core
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			req_done_o <= 1'b0;
			req_rdata_o <= 16'h0000;
			req_internal_o <= 1'b0;
			seq_busy_o <= 1'b1;
			chip_config_byte0_o <= CFG0_RESET;
			chip_config_byte1_o <= CFG1_RESET;
		end else begin
			req_done_o <= state_en && phase_q == PH_END && !cyc_is_cfg_q;
			if (state_en && phase_q == PH_END)
				req_rdata_o <= cyc_wide_q ? ad_in_i : {8'h00, ad_in_i[7:0]};
			// Internal hit: no strobes, fetch flag stays low
			req_internal_o <= seq_q == SQ_RUN && req_i && !core_ext;
			seq_busy_o <= seq_q != SQ_RUN;
			chip_config_byte0_o <= cfg0_q;
			chip_config_byte1_o <= cfg1_q;
		end
	end
endmodule

/* verif/ext_bus_mem.sv */
// Behavioural external memory sitting on the multiplexed bus
`timescale 1ns/10ps
module ext_bus_mem #(
	parameter logic [7:0] CFG0 = 8'h36,
	parameter logic [7:0] CFG1 = 8'h04
) (
	input wire logic ref_clk_i,
	input wire logic addr_strobe_i,
	input wire logic rd_n_i,
	input wire logic wrl_n_i,
	input wire logic wrh_n_i,
	input wire logic [15:0] ad_out_i,
	input wire logic [3:0] waits_i,
	output logic [15:0] ad_in_o,
	output logic ready_o
);
	logic [15:0] mem [0:32767];
	logic [15:0] addr_q = 16'h0000;
	logic [15:0] last_q = 16'h0000;
	logic [3:0] cnt_q = 4'h0;
	logic act_q = 1'b0;
	logic act;
	// Config words; the controller keeps the low byte
	initial begin
		mem[16'h100C] = {8'h00, CFG0};
		mem[16'h100D] = {8'h00, CFG1};
	end
	assign act = !(rd_n_i && wrl_n_i && wrh_n_i);
	// Latch address, store writes, count stall clock cycles per strobe
	always @(posedge ref_clk_i) begin
		act_q <= act;
		if (addr_strobe_i)
			addr_q <= ad_out_i;
		if (!wrl_n_i || !wrh_n_i)
			mem[addr_q[15:1]] <= ad_out_i;
		if (!rd_n_i)
			last_q <= ad_in_o;
		if (act && !act_q)
			cnt_q <= waits_i;
		else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
	end
	// With waits set, ready idles low, so the stall is seen before the first data edge
	assign ready_o = (waits_i == 4'h0) || (act_q && cnt_q == 4'h0);
	// Released bus shows inverted last data so stale values never match
	assign ad_in_o = !rd_n_i ? mem[addr_q[15:1]] : ~last_q;
endmodule

/* verif/ext_bus_ctrl_asserts.sv */
// Pin-level timing checks for the bus controller
`timescale 1ns/10ps
module ext_bus_ctrl_asserts
	import ext_bus_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] pin_func_en_i,
	input wire logic [7:0] general_port_io_i,
	input wire logic bus_clock_out_o,
	input wire logic addr_strobe_o,
	input wire logic rd_n_o,
	input wire logic write_low_strobe_n_o,
	input wire logic write_high_strobe_n_o,
	input wire logic fetch_indicator_o,
	input wire logic ad_oe_n_o,
	input wire logic seq_busy_o,
	input wire logic [15:0] processor_status_word_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	logic [7:0] en_prev_q;
	logic [7:0] en_hold;
	// Previous selects; a pin counts as bus-driven only once steady
	always_ff @(posedge ref_clk_i) begin
		en_prev_q <= pin_func_en_i;
	end
	assign en_hold = pin_func_en_i & en_prev_q;
	// Read phase start with the pin steadily in bus mode
	sequence rd_start;
		$fell(rd_n_o) && en_hold[2];
	endsequence
	sequence addr_start;
		$rose(addr_strobe_o) && en_hold[4:1] == 4'hF;
	endsequence
	// Any data strobe of the cycle, read or either write half
	sequence data_strobe;
		!rd_n_o || !write_low_strobe_n_o || !write_high_strobe_n_o;
	endsequence
	chk_clk_half: assert property ($past(rstn_i, 2) && en_hold[0]
		|-> bus_clock_out_o != $past(bus_clock_out_o)) else $error("bus clock not toggling");
	chk_rd_hold: assert property (rd_start |=> !rd_n_o)
		else $error("read strobe too short");
	chk_rd_bus_free: assert property (rd_start |-> ad_oe_n_o)
		else $error("bus driven on read");
	chk_rd_wr_excl: assert property (en_hold[3:2] == 2'h3
		|-> rd_n_o || write_low_strobe_n_o) else $error("read and write together");
	chk_port_rd: assert property (!pin_func_en_i[2] && !en_prev_q[2]
		|-> rd_n_o == $past(general_port_io_i[2])) else $error("port value not shown");
	chk_seq_quiet: assert property (seq_busy_o && en_hold[3] |-> write_low_strobe_n_o)
		else $error("write during reset sequence");
	chk_psw_clear: assert property (seq_busy_o |-> processor_status_word_o == PSW_RESET)
		else $error("status word not cleared");
	chk_strobe_lead: assert property (addr_start |-> ##[1:4] data_strobe)
		else $error("address strobe without access");
	chk_fetch_ext: assert property (fetch_indicator_o && en_hold[5] && en_hold[2]
		|-> !rd_n_o || !ad_oe_n_o) else $error("fetch flag outside a bus cycle");
endmodule
bind ext_bus_ctrl ext_bus_ctrl_asserts chk (.ref_clk_i, .rstn_i, .pin_func_en_i, .general_port_io_i,
	.bus_clock_out_o, .addr_strobe_o, .rd_n_o, .write_low_strobe_n_o, .write_high_strobe_n_o,
	.fetch_indicator_o, .ad_oe_n_o, .seq_busy_o, .processor_status_word_o);

/* verif/ext_bus_ctrl_bench.sv */
// Self-checking bench for the external bus controller
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("CHECK FAILED at %0t: got %h exp %h", $time, g, e); end end
module ext_bus_ctrl_bench;
	import ext_bus_pkg::*;
	logic ref_clk_i = 0, rstn_i = 0, req_i = 0, req_write_i = 0, req_fetch_i = 0;
	logic req_word_i = 1, req_internal_range_i = 0, width_select_in_i = 1;
	logic external_access_sel_n_i = 1, ready;
	logic [15:0] req_addr_i = 0, req_wdata_i = 0, ad_in, req_rdata_o, ad_out_o, e_now;
	logic [15:0] processor_status_word_o, start_pc_o, a, d;
	logic [7:0] pin_func_en_i = 8'hFF, general_port_io_i = 0;
	logic [7:0] chip_config_byte0_o, chip_config_byte1_o;
	logic [3:0] waits = 0;
	logic req_done_o, req_internal_o, bus_clock_out_o, addr_strobe_o, rd_n_o, ad_oe_n_o;
	logic write_low_strobe_n_o, write_high_strobe_n_o, fetch_indicator_o, seq_busy_o;
	logic [31:0] rng = 32'h4671;
	logic [15:0] exp_q[$];
	int miscompares = 0, total_checks = 0, cycles = 0, rd_cnt = 0;
	ext_bus_ctrl dut (.ref_clk_i, .rstn_i, .req_i, .req_write_i, .req_fetch_i, .req_word_i,
		.req_addr_i, .req_wdata_i, .req_internal_range_i, .req_done_o, .req_rdata_o,
		.req_internal_o, .width_select_in_i, .ready_i(ready), .external_access_sel_n_i,
		.ad_in_i(ad_in), .pin_func_en_i, .general_port_io_i, .bus_clock_out_o, .addr_strobe_o,
		.rd_n_o, .write_low_strobe_n_o, .write_high_strobe_n_o, .fetch_indicator_o, .ad_out_o,
		.ad_oe_n_o, .chip_config_byte0_o, .chip_config_byte1_o, .processor_status_word_o,
		.start_pc_o, .seq_busy_o);
	ext_bus_mem mem_model (.ref_clk_i, .addr_strobe_i(addr_strobe_o), .rd_n_i(rd_n_o),
		.wrl_n_i(write_low_strobe_n_o), .wrh_n_i(write_high_strobe_n_o), .ad_out_i(ad_out_o),
		.waits_i(waits), .ad_in_o(ad_in), .ready_o(ready));
	initial begin
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task end_sim;
		if (miscompares == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One external request; edge first so req_i is never set twice in a step
	task automatic op(input logic w, input logic f, input logic [15:0] ad, input logic [15:0] dw,
			input logic [15:0] e);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		if (!w)
			exp_q.push_back(e);
		req_write_i <= w;
		req_fetch_i <= f;
		req_addr_i <= ad;
		req_wdata_i <= dw;
		req_i <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (req_done_o !== 1'b1 && n < 60);
		if (n == 60)
			`CHK(1'b0, 1'b1)
		req_i <= 1'b0;
	endtask
	// Watch the pins and match read results in issue order
	always @(posedge ref_clk_i) begin
		cycles++;
		if (!rd_n_o)
			rd_cnt++;
		if (req_i && !rd_n_o)
			`CHK(fetch_indicator_o, req_fetch_i)
		if (req_done_o && !req_write_i && exp_q.size() > 0) begin
			e_now = exp_q.pop_front();
			`CHK(req_rdata_o, e_now)
		end
		if (cycles == 5000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		int n;
		n = 0;
		repeat (32) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		while (seq_busy_o !== 1'b0 && n < 200) begin
			@(posedge ref_clk_i);
			n++;
		end
		`CHK(chip_config_byte0_o, 8'h36)
		`CHK(chip_config_byte1_o, 8'h04)
		`CHK(start_pc_o, START_ADDR)
		// Random word writes and read-backs with stalls from the memory
		for (int i = 0; i < 6; i++) begin
			rng = xs(rng);
			a = rng[15:0] & 16'hFFFE;
			d = rng[31:16];
			waits <= {2'h0, rng[5:4]};
			op(1'b1, 1'b0, a, d, 16'h0000);
			op(1'b0, rng[2], a, 16'h0000, d);
		end
		// Narrow cycle returns low byte only
		width_select_in_i <= 1'b0;
		repeat (8) @(posedge ref_clk_i);
		op(1'b0, 1'b0, a, 16'h0000, {8'h00, d[7:0]});
		width_select_in_i <= 1'b1;
		// Live select pin low, but high was latched: served inside
		external_access_sel_n_i <= 1'b0;
		req_internal_range_i <= 1'b1;
		req_fetch_i <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		n = rd_cnt;
		req_i <= 1'b1;
		repeat (12) @(posedge ref_clk_i);
		`CHK(req_internal_o, 1'b1)
		`CHK(rd_cnt, n)
		`CHK(fetch_indicator_o, 1'b0)
		req_i <= 1'b0;
		req_internal_range_i <= 1'b0;
		// All function selects cleared; the read and fetch pins show their port values
		pin_func_en_i <= 8'h00;
		general_port_io_i <= rng[7:0];
		repeat (3) @(posedge ref_clk_i);
		#1;
		`CHK(rd_n_o, general_port_io_i[2])
		`CHK(fetch_indicator_o, general_port_io_i[5])
		end_sim();
	end
endmodule
